// [logic/state_effecter_enable_handler.sv]
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "effecter_enable_regs.svh"

module state_effecter_enable_handler #(
	parameter logic [15:0] OWN_HANDLE  = 16'h0001,
	parameter logic [7:0]  HAS_DEFAULT = 8'hff,
	parameter logic [7:0]  DEFAULT_VAL = 8'h00
) (
	// clock and reset
	input  wire logic                          core_clk,
	input  wire logic                          resetn,
	// apb slave
	input  wire effecter_enable_pkg::apb_req_s apb_req,
	output effecter_enable_pkg::apb_rsp_s      apb_rsp,
	// interrupt
	output logic                               irq,
	// effecter outputs
	output logic [7:0][7:0]                    effecter_value,
	output logic [7:0]                         effecter_live
);

	effecter_enable_pkg::handler_s state;
	effecter_enable_pkg::handler_s next_state;
	logic [7:0]                    field_ok;
	logic [7:0]                    live;
	logic                          handle_ok;
	logic                          count_ok;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------

	// 0x00 handle, read and write, bits 15:0
	// 0x04 count of effecters, read and write, bits 7:0
	// 0x08 number of operation fields supplied, read and write
	// 0x0c go, write only, any write runs the enable command
	// 0x10 result code of the last command, read only
	// 0x14 sticky status, read only
	//      bit 0 command done
	//      bit 1 state update refused
	//      bit 2 effecter event, a state set while its gate is on
	// 0x18 clear, write only, a one clears that status bit
	// 0x1c interrupt enable, same layout as status
	// 0x20 state set, write only
	//      bits 2:0 effecter index
	//      bits 15:8 new setting
	//      bit 16 go back to the default setting
	// 0x40 + 4 * i operation field of effecter i
	//      bits 7:0 requested operational state
	//      bits 15:8 event gate request, 0x00 on, 0x01 off, 0xff keep
	// 0x60 + 4 * i effecter i, read only
	//      bits 7:0 operational state
	//      bit 8 event gate
	//      bits 23:16 present setting
	// any other address below 0x40 or from 0x80 up answers with pslverr and read data zero

	// ------------------------------------------------------------
	// limitations
	// ------------------------------------------------------------

	// the handle is checked before the count and the fields
	// nothing is applied unless the whole request validates
	// default revert happens only when a live effecter is disabled,
	// a move to unavailable keeps the last setting
	// gate and setting read as zero while an effecter is not live
	// every access takes one wait state, pready follows a cycle later

	// ------------------------------------------------------------
	// request validation
	// ------------------------------------------------------------

	// reserved handles and foreign handles are not ours
	assign handle_ok = (state.handle != `HANDLE_RSVD_LO) &&
		(state.handle != `HANDLE_RSVD_HI) &&
		(state.handle == OWN_HANDLE);
	// count range and field total must agree
	assign count_ok = (state.count >= `COUNT_MIN) &&
		(state.count <= `COUNT_MAX) &&
		(state.fields == state.count);

	// per effecter field check and liveness
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_eff
			logic [7:0] op_req;
			logic [7:0] gate_req;
			assign op_req   = state.opf[gi][7:0];
			assign gate_req = state.opf[gi][15:8];
			// unused fields beyond the count pass
			assign field_ok[gi] = (8'(gi) >= state.count) ||
				(((op_req == effecter_enable_pkg::OP_ENABLED_PENDING) ||
				(op_req == effecter_enable_pkg::OP_ENABLED) ||
				(op_req == effecter_enable_pkg::OP_DISABLED) ||
				(op_req == effecter_enable_pkg::OP_UNAVAILABLE)) &&
				((gate_req == effecter_enable_pkg::EVENTS_ON) ||
				(gate_req == effecter_enable_pkg::EVENTS_OFF) ||
				(gate_req == effecter_enable_pkg::KEEP_UNCHANGED)));
			// disabled and unavailable effecters are not operating
			assign live[gi] =
				(state.eff_op[gi] != effecter_enable_pkg::OP_DISABLED) &&
				(state.eff_op[gi] != effecter_enable_pkg::OP_UNAVAILABLE);
		end
	endgenerate

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------

	// apb access, command execution and event collection
	always_comb begin
		logic        access;
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic        err;
		logic [2:0]  idx;
		logic [2:0]  ev_set;
		logic [2:0]  ev_clr;
		logic [7:0]  new_val;
		access     = 1'b0;
		wr         = 1'b0;
		addr       = 8'h00;
		wdata      = 32'h0000_0000;
		rdata      = 32'h0000_0000;
		err        = 1'b0;
		idx        = 3'h0;
		ev_set     = 3'h0;
		ev_clr     = 3'h0;
		new_val    = 8'h00;
		next_state = state;
		// one wait state: answer on the cycle after the first access
		access = apb_req.psel && apb_req.penable && !state.rsp.pready;
		wr     = access && apb_req.pwrite;
		addr   = apb_req.paddr;
		wdata  = apb_req.pwdata;
		idx    = addr[4:2];
		next_state.rsp.pready = access;
		// address decode
		if (addr == `OFS_HANDLE) begin
			rdata = {16'h0000, state.handle};
			if (wr) begin
				next_state.handle = wdata[15:0];
			end
		end else if (addr == `OFS_COUNT) begin
			rdata = {24'h000000, state.count};
			if (wr) begin
				next_state.count = wdata[7:0];
			end
		end else if (addr == `OFS_FIELDS) begin
			rdata = {24'h000000, state.fields};
			if (wr) begin
				next_state.fields = wdata[7:0];
			end
		end else if (addr == `OFS_GO) begin
			if (wr) begin
				ev_set[`STAT_DONE] = 1'b1;
				if (!handle_ok) begin
					next_state.result = `RC_BAD_HANDLE;
				end else if (!count_ok || (field_ok != 8'hff)) begin
					next_state.result = `RC_INVALID_DATA;
				end else begin
					next_state.result = `RC_SUCCESS;
					for (int i = 0; i < 8; i++) begin
						if (i < int'(state.count)) begin
							// switch operation on or off
							next_state.eff_op[i] = state.opf[i][7:0];
							if ((state.opf[i][7:0] ==
								effecter_enable_pkg::OP_DISABLED) &&
								live[i] && HAS_DEFAULT[i]) begin
								next_state.eff_val[i] = DEFAULT_VAL;
							end
							// event gate, keep unchanged leaves it
							if (state.opf[i][15:8] ==
								effecter_enable_pkg::EVENTS_ON) begin
								next_state.eff_gate[i] = 1'b1;
							end else if (state.opf[i][15:8] ==
								effecter_enable_pkg::EVENTS_OFF) begin
								next_state.eff_gate[i] = 1'b0;
							end
						end
					end
				end
			end
		end else if (addr == `OFS_RESULT) begin
			rdata = {24'h000000, state.result};
		end else if (addr == `OFS_STATUS) begin
			rdata = {29'h00000000, state.status};
		end else if (addr == `OFS_CLEAR) begin
			if (wr) begin
				ev_clr = wdata[2:0];
			end
		end else if (addr == `OFS_IRQ_EN) begin
			rdata = {29'h00000000, state.irq_en};
			if (wr) begin
				next_state.irq_en = wdata[2:0];
			end
		end else if (addr == `OFS_SET_STATE) begin
			if (wr) begin
				idx = wdata[2:0];
				if (wdata[`SET_TO_DEFAULT]) begin
					new_val = DEFAULT_VAL;
				end else begin
					new_val = wdata[15:8];
				end
				// no update while disabled or absent
				if (!live[idx] || (wdata[`SET_TO_DEFAULT] &&
					!HAS_DEFAULT[idx])) begin
					ev_set[`STAT_REFUSED] = 1'b1;
				end else begin
					next_state.eff_val[idx] = new_val;
					ev_set[`STAT_EVENT] = state.eff_gate[idx];
				end
			end
		end else if (addr[7:5] == `OFS_OPF_BASE) begin
			rdata = {16'h0000, state.opf[idx]};
			if (wr) begin
				next_state.opf[idx] = wdata[15:0];
			end
		end else if (addr[7:5] == `OFS_EFF_BASE) begin
			// setting and gate hidden when not operating
			if (live[idx]) begin
				rdata = {8'h00, state.eff_val[idx], 7'h00,
					state.eff_gate[idx], state.eff_op[idx]};
			end else begin
				rdata = {24'h000000, state.eff_op[idx]};
			end
		end else begin
			err = 1'b1;
		end
		if (access) begin
			next_state.rsp.prdata  = rdata;
			next_state.rsp.pslverr = err;
		end
		// sticky status, a new event wins over its clear
		next_state.status = (state.status & ~ev_clr) | ev_set;
		next_state.irq    = |(next_state.status & next_state.irq_en);
		// live flags kept in the state so the output leaves a flip-flop
		for (int i = 0; i < 8; i++) begin
			next_state.live[i] =
				(next_state.eff_op[i] == effecter_enable_pkg::OP_ENABLED) ||
				(next_state.eff_op[i] ==
				effecter_enable_pkg::OP_ENABLED_PENDING);
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------

	// asynchronous reset to constants
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state          <= '0;
			state.handle   <= `RST_HANDLE;
			state.count    <= `RST_COUNT;
			state.result   <= `RST_RESULT;
			state.eff_op   <= {8{`RST_OP_STATE}};
			state.eff_gate <= {8{`RST_GATE}};
			state.eff_val  <= {8{`RST_VALUE}};
			state.live     <= `RST_LIVE;
		end else begin
			state <= next_state;
		end
	end

	// outputs straight from the state register
	assign apb_rsp        = state.rsp;
	assign irq            = state.irq;
	assign effecter_value = state.eff_val;
	assign effecter_live  = state.live;

endmodule // state_effecter_enable_handler

// [logic/effecter_enable_regs.svh]
`ifndef EFFECTER_ENABLE_REGS_SVH
`define EFFECTER_ENABLE_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, the two bases as address bits 7:5)
// ----------------------------------------------------------------
`define OFS_HANDLE      8'h00
`define OFS_COUNT       8'h04
`define OFS_FIELDS      8'h08
`define OFS_GO          8'h0c
`define OFS_RESULT      8'h10
`define OFS_STATUS      8'h14
`define OFS_CLEAR       8'h18
`define OFS_IRQ_EN      8'h1c
`define OFS_SET_STATE   8'h20
`define OFS_OPF_BASE    3'h2
`define OFS_EFF_BASE    3'h3

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define STAT_DONE       0
`define STAT_REFUSED    1
`define STAT_EVENT      2
`define SET_TO_DEFAULT  16

// ----------------------------------------------------------------
// handle, count and result codes
// ----------------------------------------------------------------
`define HANDLE_RSVD_LO  16'h0000
`define HANDLE_RSVD_HI  16'hffff
`define COUNT_MIN       8'h01
`define COUNT_MAX       8'h08
`define RC_SUCCESS      8'h00
`define RC_INVALID_DATA 8'h02
`define RC_BAD_HANDLE   8'h80

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_HANDLE      16'h0000
`define RST_COUNT       8'h00
`define RST_RESULT      8'h00
`define RST_OP_STATE    8'h01
`define RST_GATE        1'b1
`define RST_VALUE       8'h00
`define RST_LIVE        8'hff

`endif

// [logic/effecter_enable_pkg.sv]
package effecter_enable_pkg;

	// operational state encodings, shared with the state read command
	typedef enum logic [7:0] {
		OP_ENABLED_PENDING = 8'h00,
		OP_ENABLED         = 8'h01,
		OP_DISABLED        = 8'h02,
		OP_UNAVAILABLE     = 8'h03
	} op_state_e;

	// event message gate encodings
	typedef enum logic [7:0] {
		EVENTS_ON      = 8'h00,
		EVENTS_OFF     = 8'h01,
		KEEP_UNCHANGED = 8'hff
	} gate_e;

	// apb request from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	// apb answer to the master
	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} apb_rsp_s;

	// whole state of the handler
	typedef struct packed {
		apb_rsp_s         rsp;
		logic [15:0]      handle;
		logic [7:0]       count;
		logic [7:0]       fields;
		logic [7:0][15:0] opf;
		logic [7:0][7:0]  eff_op;
		logic [7:0]       eff_gate;
		logic [7:0][7:0]  eff_val;
		logic [7:0]       result;
		logic [2:0]       status;
		logic [2:0]       irq_en;
		logic             irq;
		logic [7:0]       live;
	} handler_s;

endpackage

// [testbench/effecter_enable_checker.sv]
`timescale 1ns/1ps
// ----
// port checker
// ----
module effecter_enable_checker (
	// clock and reset
	input wire logic                          core_clk,
	input wire logic                          resetn,
	// apb
	input wire effecter_enable_pkg::apb_req_s apb_req,
	input wire effecter_enable_pkg::apb_rsp_s apb_rsp,
	// outputs
	input wire logic                          irq,
	input wire logic [7:0][7:0]               effecter_value,
	input wire logic [7:0]                    effecter_live
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// access phase seen on the bus
	wire acc = apb_req.psel && apb_req.penable;
	// bus timing and refusals
	a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready longer than one cycle");
	a_one_wait: assert property (acc && !apb_rsp.pready |=> apb_rsp.pready)
		else $error("pready not one cycle after access");
	a_ready_cause: assert property (apb_rsp.pready |-> $past(acc))
		else $error("pready without access");
	a_err_data: assert property (apb_rsp.pready && apb_rsp.pslverr
		|-> apb_rsp.prdata == 32'h0) else $error("error with data");
	a_unmapped_err: assert property (apb_rsp.pready
		&& apb_req.paddr == 8'h24 |-> apb_rsp.pslverr)
		else $error("unmapped address accepted");
	// effecter outputs and irq move only through an access
	a_value_still: assert property (!acc |=> $stable(effecter_value))
		else $error("value changed without access");
	a_live_still: assert property (!acc |=> $stable(effecter_live))
		else $error("live changed without access");
	a_irq_still: assert property (!acc |=> $stable(irq))
		else $error("irq changed without access");
endmodule // effecter_enable_checker

// [testbench/mgmt_master.sv]
`timescale 1ns/1ps
// ----
// controller side apb master
// ----
module mgmt_master (
	// clock
	input wire logic                          core_clk,
	// apb
	output effecter_enable_pkg::apb_req_s     apb_req,
	input wire effecter_enable_pkg::apb_rsp_s apb_rsp
);
	initial apb_req = '0;
	// setup, access until pready, then release with scrambled lines
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic err);
		@(posedge core_clk);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge core_clk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (!apb_rsp.pready);
		q = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req <= '{1'b0, 1'b0, ~w, ~a, ~d};
	endtask
endmodule // mgmt_master

// [testbench/state_effecter_enable_handler_tb.sv]
`timescale 1ns/1ps
// ----
// bench top
// ----
module state_effecter_enable_handler_tb;
	logic                          core_clk = 1'b0;
	logic                          resetn = 1'b0;
	effecter_enable_pkg::apb_req_s apb_req;
	effecter_enable_pkg::apb_rsp_s apb_rsp;
	logic                          irq;
	logic [7:0][7:0]               effecter_value;
	logic [7:0]                    effecter_live;
	logic [31:0]                   r;
	logic                          e;
	int                            bad_count = 0;
	int                            total_checks = 0;
	state_effecter_enable_handler i_state_effecter_enable_handler (
		.core_clk(core_clk), .resetn(resetn), .apb_req(apb_req),
		.apb_rsp(apb_rsp), .irq(irq), .effecter_value(effecter_value),
		.effecter_live(effecter_live));
	mgmt_master i_mgmt_master (.core_clk(core_clk), .apb_req(apb_req),
		.apb_rsp(apb_rsp));
	// clock
	always #2 core_clk = ~core_clk;
	// compare, bus and command helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_mgmt_master.xfer(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a);
		i_mgmt_master.xfer(1'b0, a, 32'h0, r, e);
	endtask
	task automatic cmd(input logic [15:0] h, input logic [7:0] c, f, rc);
		wr(8'h00, {16'h0, h});
		wr(8'h04, {24'h0, c});
		wr(8'h08, {24'h0, f});
		wr(8'h0c, 32'h1);
		rd(8'h10);
		chk(r, {24'h0, rc});
	endtask
	task automatic irq_is(input logic x);
		@(posedge core_clk);
		chk({31'h0, irq}, {31'h0, x});
	endtask
	// reset values and unmapped read
	task automatic t_reset;
		chk({24'h0, effecter_live}, 32'hff);
		rd(8'h60);
		chk(r, 32'h101);
		rd(8'h24);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
	endtask
	// refused requests leave the effecters unchanged
	task automatic t_refuse;
		wr(8'h40, 32'h0102);
		cmd(16'h0000, 8'h1, 8'h1, 8'h80);
		cmd(16'hffff, 8'h1, 8'h1, 8'h80);
		cmd(16'h0002, 8'h1, 8'h1, 8'h80);
		cmd(16'h0001, 8'h0, 8'h0, 8'h02);
		cmd(16'h0001, 8'h9, 8'h9, 8'h02);
		cmd(16'h0001, 8'h1, 8'h2, 8'h02);
		wr(8'h40, 32'h0104);
		cmd(16'h0001, 8'h1, 8'h1, 8'h02);
		wr(8'h40, 32'h0201);
		cmd(16'h0001, 8'h1, 8'h1, 8'h02);
		chk({24'h0, effecter_live}, 32'hff);
	endtask
	// apply states and gates
	task automatic t_apply;
		wr(8'h18, 32'h7);
		wr(8'h20, 32'h5a03);
		chk({24'h0, effecter_value[3]}, 32'h5a);
		rd(8'h14);
		chk(r, 32'h4);
		wr(8'h40, 32'h0102);
		wr(8'h44, 32'h0003);
		wr(8'h48, 32'hff01);
		wr(8'h4c, 32'h0102);
		cmd(16'h0001, 8'h4, 8'h4, 8'h00);
		chk({24'h0, effecter_live}, 32'hf4);
		chk({24'h0, effecter_value[3]}, 32'h0);
		rd(8'h60);
		chk(r, 32'h2);
		rd(8'h64);
		chk(r, 32'h3);
		rd(8'h68);
		chk(r, 32'h101);
		wr(8'h48, 32'h0101);
		cmd(16'h0001, 8'h3, 8'h3, 8'h00);
		rd(8'h68);
		chk(r, 32'h001);
		wr(8'h48, 32'hff00);
		cmd(16'h0001, 8'h3, 8'h3, 8'h00);
		rd(8'h68);
		chk(r, 32'h000);
	endtask
	// state set: refusal, default, gated event
	task automatic t_state;
		wr(8'h18, 32'h7);
		wr(8'h20, 32'h7700);
		rd(8'h14);
		chk(r, 32'h2);
		chk({24'h0, effecter_value[0]}, 32'h0);
		wr(8'h20, 32'h3304);
		chk({24'h0, effecter_value[4]}, 32'h33);
		wr(8'h20, 32'h10004);
		chk({24'h0, effecter_value[4]}, 32'h0);
		wr(8'h18, 32'h7);
		wr(8'h20, 32'h1102);
		rd(8'h14);
		chk(r, 32'h0);
	endtask
	// interrupt raised, masked, cleared
	task automatic t_irq;
		wr(8'h18, 32'h7);
		wr(8'h1c, 32'h1);
		irq_is(1'b0);
		wr(8'h0c, 32'h1);
		irq_is(1'b1);
		wr(8'h1c, 32'h0);
		irq_is(1'b0);
		wr(8'h1c, 32'h1);
		irq_is(1'b1);
		wr(8'h18, 32'h1);
		irq_is(1'b0);
	endtask
	// verdict and end of run
	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		t_reset();
		t_refuse();
		t_apply();
		t_state();
		t_irq();
		wrap_up();
	end
	// watchdog
	initial begin
		#40000;
		bad_count++;
		wrap_up();
	end
endmodule // state_effecter_enable_handler_tb

bind state_effecter_enable_handler effecter_enable_checker
	i_effecter_enable_checker (.core_clk(core_clk), .resetn(resetn),
	.apb_req(apb_req), .apb_rsp(apb_rsp), .irq(irq),
	.effecter_value(effecter_value), .effecter_live(effecter_live));
